// *** pkg/lbus_pkg.sv ***
/*
  Package for the processor local bus cycle handshake: widths, depths, burst length
  and controller states.
  Assumes one synchronous core clock shared by all users of the package.
*/
`default_nettype none
package lbus_pkg;
  localparam int unsigned ADDR_W     = 32;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned BE_W       = 4;
  localparam int unsigned WBUF_DEPTH = 4;
  localparam int unsigned WBUF_PTR_W = 2;
  localparam int unsigned WBUF_CNT_W = 3;
  localparam int unsigned BURST_LEN  = 4;
  localparam int unsigned BEAT_W     = 2;
  localparam int unsigned WORD_OFS_LO = 2;
  localparam logic [BEAT_W-1:0] BEAT_LAST = 2'h3;
  localparam logic [BEAT_W-1:0] BEAT_ZERO = 2'h0;
  localparam logic [WBUF_CNT_W-1:0] WBUF_FULL_CNT = 3'h4;
  localparam logic [WBUF_CNT_W-1:0] WBUF_EMPTY_CNT = 3'h0;
  localparam logic [WBUF_CNT_W-1:0] WBUF_ONE = 3'h1;
  localparam logic [WBUF_PTR_W-1:0] PTR_ONE = 2'h1;

  // Bus controller states: idle, first clock, second clock and wait clocks.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_T1,
    ST_T2
  } bus_state_t;
endpackage : lbus_pkg
`default_nettype wire

// *** hw/wbuf_fifo.sv ***
/*
  Posted-write buffer holding address, data and byte enables of pending writes.
  Assumes the bus controller pops the head only when its write cycle completes.
*/
`timescale 1ns/1ps
`default_nettype none
module wbuf_fifo (
  input  wire logic                          core_clk,
  input  wire logic                          rst_n,
  input  wire logic                          push,
  input  wire logic [lbus_pkg::ADDR_W-1:0]   push_addr,
  input  wire logic [lbus_pkg::DATA_W-1:0]   push_data,
  input  wire logic [lbus_pkg::BE_W-1:0]     push_be,
  input  wire logic                          pop,
  output logic [lbus_pkg::ADDR_W-1:0]        head_addr,
  output logic [lbus_pkg::DATA_W-1:0]        head_data,
  output logic [lbus_pkg::BE_W-1:0]          head_be,
  output logic                               empty,
  output logic                               full
);
  import lbus_pkg::*;

  logic [ADDR_W-1:0]     addr_mem [WBUF_DEPTH];
  logic [DATA_W-1:0]     data_mem [WBUF_DEPTH];
  logic [BE_W-1:0]       be_mem   [WBUF_DEPTH];
  logic [WBUF_PTR_W-1:0] wr_ptr_q;
  logic [WBUF_PTR_W-1:0] rd_ptr_q;
  logic [WBUF_CNT_W-1:0] cnt_q;
  logic                  do_push;
  logic                  do_pop;

  // Push is refused when full; pop is ignored when empty.
  assign do_push = push && (cnt_q != WBUF_FULL_CNT);
  assign do_pop  = pop && (cnt_q != WBUF_EMPTY_CNT);
  assign empty   = (cnt_q == WBUF_EMPTY_CNT);
  assign full    = (cnt_q == WBUF_FULL_CNT);
  assign head_addr = addr_mem[rd_ptr_q];
  assign head_data = data_mem[rd_ptr_q];
  assign head_be   = be_mem[rd_ptr_q];

  // Storage array, written at the tail.
  always_ff @(posedge core_clk) begin
    if (do_push) begin
      addr_mem[wr_ptr_q] <= push_addr;
      data_mem[wr_ptr_q] <= push_data;
      be_mem[wr_ptr_q]   <= push_be;
    end
  end

  // Pointers and occupancy.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= WBUF_EMPTY_CNT;
    end else begin
      if (do_push) wr_ptr_q <= wr_ptr_q + PTR_ONE;
      if (do_pop)  rd_ptr_q <= rd_ptr_q + PTR_ONE;
      if (do_push && !do_pop) cnt_q <= cnt_q + WBUF_ONE;
      else if (do_pop && !do_push) cnt_q <= cnt_q - WBUF_ONE;
    end
  end
endmodule : wbuf_fifo
`default_nettype wire

// *** hw/lbus_cycle_ctrl.sv ***
/*
  Processor-side local bus cycle controller: runs non-burst reads, four-beat burst
  line fills and write-through writes drained from a four-entry posted-write buffer.
  Assumes the external memory controller answers synchronously to core_clk and keeps
  its own handshake and DRAM sequencing duties.
*/
`timescale 1ns/1ps
`default_nettype none
module lbus_cycle_ctrl (
  input  wire logic                        core_clk,
  input  wire logic                        arst_n,
  // Core request side.
  input  wire logic                        rd_req,
  input  wire logic                        rd_burst_ok,
  input  wire logic [lbus_pkg::ADDR_W-1:0] rd_addr,
  output logic                             rd_ack,
  output logic                             rd_data_valid,
  output logic [lbus_pkg::DATA_W-1:0]      rd_data,
  output logic                             rd_done,
  input  wire logic                        wr_req,
  input  wire logic [lbus_pkg::ADDR_W-1:0] wr_addr,
  input  wire logic [lbus_pkg::DATA_W-1:0] wr_data,
  input  wire logic [lbus_pkg::BE_W-1:0]   wr_be,
  output logic                             wr_ready,
  // External bus side.
  output logic                             addr_strobe_n,
  output logic [lbus_pkg::ADDR_W-1:0]      bus_addr,
  output logic [lbus_pkg::BE_W-1:0]        bus_be_n,
  output logic                             bus_write,
  output logic [lbus_pkg::DATA_W-1:0]      bus_data_out,
  output logic                             bus_data_oe,
  input  wire logic [lbus_pkg::DATA_W-1:0] bus_data_in,
  input  wire logic                        cycle_done_n,
  input  wire logic                        burst_done_n,
  output logic                             last_transfer_n
);
  import lbus_pkg::*;

  logic                  rst_meta_q;
  logic                  rst_n;
  bus_state_t            state_q;
  logic [BEAT_W-1:0]     beat_q;
  logic                  is_burst_q;
  logic                  wb_empty;
  logic                  wb_full;
  logic [ADDR_W-1:0]     wb_addr;
  logic [DATA_W-1:0]     wb_data;
  logic [BE_W-1:0]       wb_be;
  logic                  wb_pop;
  logic                  done_seen;
  logic                  burst_seen;
  logic                  cyc_end;
  logic                  start_wr;
  logic                  start_rd;
  logic                  wr_push;
  logic [WBUF_CNT_W-1:0] occ_q;
  logic [WBUF_CNT_W-1:0] occ_d;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Posted writes enter the buffer whenever it has room.
  assign wr_push = wr_req && !wb_full;

  wbuf_fifo u_wbuf (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .push      (wr_push),
    .push_addr (wr_addr),
    .push_data (wr_data),
    .push_be   (wr_be),
    .pop       (wb_pop),
    .head_addr (wb_addr),
    .head_data (wb_data),
    .head_be   (wb_be),
    .empty     (wb_empty),
    .full      (wb_full)
  );

  // Shadow of the buffer occupancy one clock ahead, so ready needs nothing inside the buffer.
  always_comb begin
    occ_d = occ_q;
    if (wr_push && !wb_pop) begin
      occ_d = occ_q + WBUF_ONE;
    end else if (wb_pop && !wr_push) begin
      occ_d = occ_q - WBUF_ONE;
    end
  end

  // Occupancy register, counting exactly the pushes and pops the buffer accepts.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) occ_q <= WBUF_EMPTY_CNT;
    else        occ_q <= occ_d;
  end

  // Ready registered from the next occupancy so the output comes from a flip-flop.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) wr_ready <= 1'b0;
    else        wr_ready <= (occ_d != WBUF_FULL_CNT);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Done strobes are only looked at from the second clock on, every clock.
  assign done_seen  = (state_q == ST_T2) && !cycle_done_n;
  assign burst_seen = (state_q == ST_T2) && !burst_done_n && !bus_write;
  // A cycle ends on cycle_done_n, or on burst_done_n at the last beat or when no burst.
  assign cyc_end = done_seen ||
                   (burst_seen && (!is_burst_q || beat_q == BEAT_LAST)) ||
                   ((state_q == ST_T2) && bus_write && !burst_done_n);
  // Writes drain ahead of reads so every write reaches memory in order.
  assign start_wr = (state_q == ST_IDLE) && !wb_empty;
  assign start_rd = (state_q == ST_IDLE) && wb_empty && rd_req;
  assign wb_pop   = (state_q == ST_T2) && bus_write && cyc_end;

  // Bus state machine: T1 presents address, T2 repeats until completion.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (start_wr || start_rd) state_q <= ST_T1;
        end
        ST_T1: begin
          state_q <= ST_T2;
        end
        ST_T2: begin
          if (cyc_end) state_q <= ST_IDLE;
        end
        // The fourth code of the state register is unused; recover to idle.
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Cycle attributes and burst beat count.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      is_burst_q <= 1'b0;
      beat_q     <= BEAT_ZERO;
    end else if (state_q == ST_IDLE) begin
      beat_q <= BEAT_ZERO;
      if (start_rd) is_burst_q <= rd_burst_ok;
      else          is_burst_q <= 1'b0;
    end else if (burst_seen && !cyc_end) begin
      is_burst_q <= is_burst_q;
      beat_q     <= beat_q + 2'h1;
    end else if (done_seen) begin
      is_burst_q <= 1'b0;
    end
  end

  // Address, direction and write data driven for the whole cycle.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_strobe_n <= 1'b1;
      bus_addr      <= '0;
      bus_be_n      <= '1;
      bus_write     <= 1'b0;
      bus_data_out  <= '0;
      bus_data_oe   <= 1'b0;
    end else begin
      addr_strobe_n <= !(start_wr || start_rd);
      if (start_wr) begin
        bus_addr     <= wb_addr;
        bus_be_n     <= ~wb_be;
        bus_write    <= 1'b1;
        bus_data_out <= wb_data;
        bus_data_oe  <= 1'b1;
      end else if (start_rd) begin
        bus_addr    <= rd_addr;
        bus_be_n    <= '0;
        bus_write   <= 1'b0;
        bus_data_oe <= 1'b0;
      end else if (burst_seen && !cyc_end) begin
        // Advance the word address by one per beat, wrapping inside the line.
        bus_addr[WORD_OFS_LO +: BEAT_W] <= bus_addr[WORD_OFS_LO +: BEAT_W] + 2'h1;
      end else if (state_q == ST_T2 && cyc_end) begin
        bus_data_oe <= 1'b0;
        bus_write   <= 1'b0;
      end
    end
  end

  // Burst capability: high in the second clock of a burst-capable read, low on its final beat and in non-burst reads and writes.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_transfer_n <= 1'b1;
    end else if (start_rd) begin
      last_transfer_n <= rd_burst_ok;
    end else if (start_wr) begin
      last_transfer_n <= 1'b0;
    end else if (burst_seen && !cyc_end) begin
      last_transfer_n <= (beat_q + 2'h1 != BEAT_LAST);
    end else if (done_seen) begin
      last_transfer_n <= 1'b1;
    end
  end

  // Read data returned to the cache one word per completing clock.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_valid <= 1'b0;
      rd_data       <= '0;
      rd_done       <= 1'b0;
      rd_ack        <= 1'b0;
    end else begin
      rd_ack        <= start_rd;
      rd_data_valid <= !bus_write && (done_seen || burst_seen);
      rd_done       <= !bus_write && cyc_end;
      if (!bus_write && (done_seen || burst_seen)) rd_data <= bus_data_in;
    end
  end
endmodule : lbus_cycle_ctrl
`default_nettype wire

// *** testbench/lbus_cycle_ctrl_properties.sv ***
/* Checker for the local bus cycle controller.
   Assumes it is bound to lbus_cycle_ctrl and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module lbus_cycle_ctrl_properties (
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire logic        rd_ack,
  input wire logic        rd_burst_ok,
  input wire logic        rd_data_valid,
  input wire logic [31:0] rd_data,
  input wire logic        rd_done,
  input wire logic        addr_strobe_n,
  input wire logic [31:0] bus_addr,
  input wire logic        bus_write,
  input wire logic        bus_data_oe,
  input wire logic [31:0] bus_data_in,
  input wire logic        cycle_done_n,
  input wire logic        burst_done_n,
  input wire logic        last_transfer_n
);
  logic in_t2_q;
  logic ends;
  // A cycle ends on a plain done, or on a burst done with the final-beat mark.
  assign ends = in_t2_q && (!cycle_done_n || (!burst_done_n && !last_transfer_n));
  // Marks the second and wait clocks of each bus cycle.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) in_t2_q <= 1'b0;
    else if (!addr_strobe_n) in_t2_q <= 1'b1;
    else if (ends) in_t2_q <= 1'b0;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  a_strobe_pulse: assert property (!addr_strobe_n |=> addr_strobe_n)
    else $error("address strobe held past first clock");
  a_zero_wait: assert property (
    (!addr_strobe_n && !bus_write) ##1 !cycle_done_n |=> rd_done)
    else $error("zero wait read not done in two clocks");
  a_wait_extends: assert property (
    in_t2_q && cycle_done_n && burst_done_n |=> addr_strobe_n && !rd_done && $stable(bus_addr))
    else $error("cycle left during wait");
  a_burst_capable: assert property (rd_ack && rd_burst_ok |=> last_transfer_n)
    else $error("last transfer asserted in second clock");
  a_beat_data: assert property (
    in_t2_q && !bus_write && !(burst_done_n && cycle_done_n)
    |=> rd_data_valid && rd_data == $past(bus_data_in))
    else $error("read word lost");
  a_beat_addr: assert property (
    in_t2_q && !burst_done_n && cycle_done_n && last_transfer_n
    |=> bus_addr[3:2] == $past(bus_addr[3:2]) + 2'h1)
    else $error("beat address not advanced");
  a_write_drive: assert property (
    !addr_strobe_n && bus_write |-> bus_data_oe ##1 bus_data_oe)
    else $error("write data not driven");
  a_done_cause: assert property (rd_done |-> $past(ends))
    else $error("read done without completion strobe");
  a_burst_end: assert property (ends && !bus_write |=> rd_done ##1 addr_strobe_n)
    else $error("read end not reported");
endmodule // lbus_cycle_ctrl_properties
bind lbus_cycle_ctrl lbus_cycle_ctrl_properties u_props (.core_clk, .arst_n, .rd_ack,
  .rd_burst_ok, .rd_data_valid, .rd_data, .rd_done, .addr_strobe_n, .bus_addr, .bus_write,
  .bus_data_oe, .bus_data_in, .cycle_done_n, .burst_done_n, .last_transfer_n);
`default_nettype wire

// *** testbench/mem_ctrl_model.sv ***
/* Model of the external memory controller answering bus cycles.
   Assumes it runs on the processor clock; waits and burst_mode set before a cycle. */
`timescale 1ns/1ps
`default_nettype none
module mem_ctrl_model (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic [3:0]  waits,
  input  wire logic        burst_mode,
  input  wire logic        addr_strobe_n,
  input  wire logic [31:0] bus_addr,
  input  wire logic        bus_write,
  input  wire logic        last_transfer_n,
  output logic             cycle_done_n,
  output logic             burst_done_n,
  output logic [31:0]      bus_data_in,
  output logic             row_strobe_n,
  output logic             col_strobe_n,
  output logic [15:0]      dram_addr
);
  logic       act_q;
  logic [3:0] cnt_q;
  logic       done;
  // Answers once the wait count runs out; released data shows the inverse.
  assign done = act_q && cnt_q == waits;
  assign cycle_done_n = !(done && (bus_write || !burst_mode));
  assign burst_done_n = !(done && !bus_write && burst_mode);
  assign bus_data_in = done ? ~bus_addr : bus_addr;
  assign row_strobe_n = !act_q;
  assign dram_addr = (cnt_q == 4'h0) ? bus_addr[31:16] : bus_addr[15:0];
  assign col_strobe_n = !(act_q && (cnt_q != 4'h0 || done));
  // Counts wait clocks; after the first burst word, one word per clock.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      act_q <= 1'b0;
      cnt_q <= 4'h0;
    end else if (!addr_strobe_n) begin
      act_q <= 1'b1;
      cnt_q <= 4'h0;
    end else if (done) begin
      act_q <= cycle_done_n && last_transfer_n;
    end else if (act_q) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule // mem_ctrl_model
`default_nettype wire

// *** testbench/test_lbus_cycle_ctrl.sv ***
/* Self-checking bench for the local bus cycle controller.
   Assumes the package is compiled first and the memory model answers the bus. */
`timescale 1ns/1ps
`default_nettype none
module test_lbus_cycle_ctrl;
  logic        core_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        rd_req = 1'b0;
  logic        rd_burst_ok = 1'b0;
  logic        wr_req = 1'b0;
  logic        burst_mode = 1'b0;
  logic [3:0]  waits = 4'h0;
  logic [3:0]  wr_be = 4'h5;
  logic [31:0] rd_addr = 32'h0;
  logic [31:0] wr_addr = 32'h0;
  logic [31:0] wr_data = 32'h0;
  logic        rd_ack, rd_data_valid, rd_done, wr_ready, addr_strobe_n, bus_write;
  logic        bus_data_oe, cycle_done_n, burst_done_n, last_transfer_n;
  logic [31:0] rd_data, bus_addr, bus_data_out, bus_data_in, wq[$], wa[$];
  logic [3:0]  bus_be_n, wbe;
  logic        row_strobe_n, col_strobe_n;
  logic [15:0] dram_addr;
  int          n_errors = 0, compares = 0, cyc = 0, wdone = 0;

  lbus_cycle_ctrl u_lbus_cycle_ctrl (.core_clk, .arst_n, .rd_req, .rd_burst_ok, .rd_addr,
    .rd_ack, .rd_data_valid, .rd_data, .rd_done, .wr_req, .wr_addr, .wr_data, .wr_be,
    .wr_ready, .addr_strobe_n, .bus_addr, .bus_be_n, .bus_write, .bus_data_out,
    .bus_data_oe, .bus_data_in, .cycle_done_n, .burst_done_n, .last_transfer_n);
  mem_ctrl_model u_mem_ctrl_model (.core_clk, .arst_n, .waits, .burst_mode, .addr_strobe_n,
    .bus_addr, .bus_write, .last_transfer_n, .cycle_done_n, .burst_done_n, .bus_data_in,
    .row_strobe_n, .col_strobe_n, .dram_addr);

  // Clock, cycle ceiling and a log of write cycles seen on the bus.
  initial forever #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (addr_strobe_n === 1'b0 && bus_write === 1'b1) begin
      wq.push_back(bus_data_out);
      wa.push_back(bus_addr);
      wbe = bus_be_n;
    end
    if (cycle_done_n === 1'b0 && bus_write === 1'b1) wdone++;
    // The memory side must have row and column open in the clock it answers.
    if (cycle_done_n === 1'b0 || burst_done_n === 1'b0) begin
      chk("row strobe", 32'h0, {31'h0, row_strobe_n});
      chk("column strobe", 32'h0, {31'h0, col_strobe_n});
    end
    if (cyc == 3000) begin
      n_errors++;
      conclude();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // One read: words are checked in beat order, then the clock count from acknowledge.
  task automatic do_read(input logic [31:0] a, input logic ok, input logic [3:0] w,
                         input logic bm, input int nw, input int lat);
    int t, k;
    logic [31:0] ea;
    @(negedge core_clk);
    waits = w;
    burst_mode = bm;
    rd_addr = a;
    rd_burst_ok = ok;
    rd_req = 1'b1;
    t = 0;
    while (rd_ack !== 1'b1 && t < 50) begin
      @(negedge core_clk);
      t++;
    end
    rd_req = 1'b0;
    t = 0;
    k = 0;
    do begin
      @(negedge core_clk);
      t++;
      if (rd_data_valid === 1'b1) begin
        ea = a;
        ea[3:2] = a[3:2] + k[1:0];
        chk("read word", ~ea, rd_data);
        k++;
      end
    end while (rd_done !== 1'b1 && t < 60);
    chk("read clocks", lat, t);
    chk("read words", nw, k);
  endtask

  task automatic t_plain();
    do_read(32'h0000_1000, 1'b0, 4'h0, 1'b0, 1, 2);
    $display("test plain read done");
  endtask

  task automatic t_wait();
    do_read(32'h0000_2004, 1'b0, 4'h3, 1'b0, 1, 5);
    do_read(32'h0000_2104, 1'b0, 4'h2, 1'b1, 1, 4);
    $display("test wait read done");
  endtask

  task automatic t_burst();
    do_read(32'h0000_3008, 1'b1, 4'h0, 1'b1, 4, 5);
    do_read(32'h0000_300c, 1'b1, 4'h3, 1'b1, 4, 8);
    do_read(32'h0000_4000, 1'b1, 4'h1, 1'b0, 1, 3);
    $display("test burst read done");
  endtask

  // Slow memory: the buffer must take four writes, then drain them in order.
  task automatic t_write();
    int n, t;
    n = 0;
    wq.delete();
    wa.delete();
    wdone = 0;
    @(negedge core_clk);
    waits = 4'h8;
    for (int i = 0; i < 8; i++) begin
      wr_addr = 32'h0000_0100 + 32'(4 * n);
      wr_data = 32'hd000_0000 + 32'(n);
      wr_req = wr_ready;
      if (wr_ready === 1'b1) n++;
      @(negedge core_clk);
    end
    wr_req = 1'b0;
    chk("writes taken", 4, n);
    t = 0;
    while (wdone < 4 && t < 200) begin
      @(negedge core_clk);
      t++;
    end
    chk("write completions", 4, wdone);
    chk("write cycles", 4, wq.size());
    for (int i = 0; i < 4; i++) chk("write data", 32'hd000_0000 + 32'(i), wq[i]);
    for (int i = 0; i < 4; i++) chk("write address", 32'h0000_0100 + 32'(4 * i), wa[i]);
    chk("write byte enables", 32'h0000_000a, {28'h0, wbe});
    $display("test write buffer done");
  endtask

  initial begin
    repeat (16) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    t_plain();
    t_wait();
    t_burst();
    t_write();
    conclude();
  end
endmodule // test_lbus_cycle_ctrl
`default_nettype wire
